// [rtl/led_mode_defs.vh]
// constants for the led driver mode, fault and interrupt register block
`ifndef LED_MODE_DEFS_VH
`define LED_MODE_DEFS_VH

// serial bus address and synchronised input pin indices
`define DEV_ADDR        7'h2a
`define PIN_COUNT       6
`define PIN_IDLE        6'h03
`define PIN_SCL         0
`define PIN_SDA         1
`define PIN_SHORT       2
`define PIN_THERMAL     3
`define PIN_OVP         4
`define PIN_UVLO        5

// register offsets
`define OFS_MODE        8'h01
`define OFS_STATUS      8'h02
`define OFS_IRQ_EN      8'h03

// field positions
`define BIT_INT_CFG     6
`define BIT_ACTIVE      5
`define BIT_DIM         4
`define BIT_GAIN_DIS    3
`define BIT_SYNC_INDEP_SINK_ENABLE      2
`define BIT_BACKLIGHT_ENABLE       0
`define BIT_SHORT       4
`define BIT_THERMAL     3
`define BIT_OVP         2

// writable bit masks and reset value
`define MASK_MODE       8'h7d
`define MASK_FAULT      8'h1c
`define REG_RESET       8'h00

// timing
`define CLK_MHZ         125
`define IRQ_RELEASE_US  50
`define IRQ_RELEASE_CYC (`IRQ_RELEASE_US * `CLK_MHZ)
`define REL_CNT_W       13

`endif

// [rtl/pin_sync.v]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter IDLE_VAL = 1'b0
) (
    // clock and reset
    input  wire clk_in,
    input  wire resetn_in,
    // pin and filtered level
    input  wire pin_in,
    output wire level_out
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg level_reg;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_reg    <= IDLE_VAL;
            s2_reg    <= IDLE_VAL;
            s3_reg    <= IDLE_VAL;
            level_reg <= IDLE_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // change taken once stages two and three agree
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign level_out = level_reg;
endmodule // pin_sync

// [rtl/led_mode_irq.v]
// led driver mode control, fault flags and host interrupt behind a serial slave
//
// Contract
// - cfg 1: release irq 50 us, reassert
// - cfg 0: irq stays while events pending
// - active bit 1 active, else standby
// - hardware sets dim bit on timeout
// - dim takes effect only with backlight enable
// - gain-down disable holds gain until leds off
// - sync bit switches all independent sinks
// - sync bit ignored if per-sink enables set
// - backlight runs only when enabled and active
// - short fault sets status bit 4
// - thermal fault sets status bit 3
// - overvoltage fault sets status bit 2
// - fault flags clear only by writing one
// - enabled pending flag raises host irq
// - disabled fault still flags, no irq
// - reserved bits read as zero
// - reset or undervoltage zeroes all registers
// - slave address 0x2a, bytes 0x54/0x55
`timescale 1ns/1ps
`include "led_mode_defs.vh"
module led_mode_irq #(
    parameter RELEASE_CYCLES = `IRQ_RELEASE_CYC
) (
    // clock and reset
    input  wire       clk_in,
    input  wire       resetn_in,
    // serial bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_out,
    // analog fault detectors and undervoltage lockout
    input  wire       short_det_in,
    input  wire       thermal_det_in,
    input  wire       ovp_det_in,
    input  wire       uvlo_in,
    // backlight and sink logic, same clock
    input  wire       dim_timeout_in,
    input  wire       leds_all_off_in,
    input  wire [6:0] per_sink_enable_in,
    input  wire [6:0] indep_sink_sel_in,
    // controls to the rest of the device
    output wire       active_out,
    output wire       backlight_on_out,
    output wire       dim_active_out,
    output wire       pump_gain_down_allow_out,
    output wire [6:0] indep_sink_on_out,
    // host interrupt
    output wire       irq_n_out
);
    localparam S_IDLE  = 3'd0;
    localparam S_ADDR  = 3'd1;
    localparam S_REG   = 3'd2;
    localparam S_WDATA = 3'd3;
    localparam S_ACK   = 3'd4;
    localparam S_RDATA = 3'd5;
    localparam S_RACK  = 3'd6;

    localparam [`REL_CNT_W-1:0] REL_LOAD = RELEASE_CYCLES[`REL_CNT_W-1:0];
    localparam [`REL_CNT_W-1:0] REL_ZERO = {`REL_CNT_W{1'b0}};
    localparam [`REL_CNT_W-1:0] REL_ONE  = {{(`REL_CNT_W-1){1'b0}}, 1'b1};

    wire [`PIN_COUNT-1:0] pin_raw;
    wire [`PIN_COUNT-1:0] pin_lvl;
    localparam [`PIN_COUNT-1:0] PIN_IDLE_V = `PIN_IDLE;

    assign pin_raw = {uvlo_in, ovp_det_in, thermal_det_in, short_det_in, sda_in, scl_in};

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
            pin_sync #(
                .IDLE_VAL (PIN_IDLE_V[gi])
            ) u_sync (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .pin_in    (pin_raw[gi]),
                .level_out (pin_lvl[gi])
            );
        end
    endgenerate

    wire scl = pin_lvl[`PIN_SCL];
    wire sda = pin_lvl[`PIN_SDA];
    wire uvlo = pin_lvl[`PIN_UVLO];

    reg                   scl_prev_reg;
    reg                   sda_prev_reg;
    reg [2:0]             st_reg;
    reg [2:0]             nx_reg;
    reg [2:0]             bit_cnt_reg;
    reg [7:0]             shift_reg;
    reg [7:0]             ptr_reg;
    reg                   got_reg;
    reg                   sda_oe_reg;
    reg                   sda_out_reg;
    reg [7:0]             mode_reg;
    reg [7:0]             status_reg;
    reg [7:0]             irq_en_reg;
    reg [`REL_CNT_W-1:0]  rel_cnt_reg;
    reg                   irq_n_reg;
    reg                   active_reg;
    reg                   bl_on_reg;
    reg                   dim_act_reg;
    reg                   gain_allow_reg;
    reg [6:0]             sink_on_reg;

    wire scl_rise = scl & ~scl_prev_reg;
    wire scl_fall = ~scl & scl_prev_reg;
    wire bus_start = scl & scl_prev_reg & sda_prev_reg & ~sda;
    wire bus_stop = scl & scl_prev_reg & ~sda_prev_reg & sda;
    wire [7:0] rx_byte = {shift_reg[6:0], sda};

    // register write strobe on the eighth data bit
    wire wr_stb = scl_rise & (st_reg == S_WDATA) & (bit_cnt_reg == 3'd7);
    wire wr_mode = wr_stb & (ptr_reg == `OFS_MODE);
    wire wr_status = wr_stb & (ptr_reg == `OFS_STATUS);
    wire wr_irq_en = wr_stb & (ptr_reg == `OFS_IRQ_EN);

    // a clear attempt is any one written to a fault flag
    wire clr_try = wr_status & (|(rx_byte & `MASK_FAULT));

    reg [7:0] rd_byte;
    always @* begin
        case (ptr_reg)
            `OFS_MODE:   rd_byte = mode_reg & `MASK_MODE;
            `OFS_STATUS: rd_byte = status_reg & `MASK_FAULT;
            `OFS_IRQ_EN: rd_byte = irq_en_reg & `MASK_FAULT;
            default:     rd_byte = `REG_RESET;
        endcase
    end

    // serial slave
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            st_reg       <= S_IDLE;
            nx_reg       <= S_IDLE;
            bit_cnt_reg  <= 3'd0;
            shift_reg    <= 8'h00;
            ptr_reg      <= 8'h00;
            got_reg      <= 1'b0;
            sda_oe_reg   <= 1'b0;
            sda_out_reg  <= 1'b0;
        end else begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
            sda_out_reg  <= 1'b0;
            if (uvlo) begin
                st_reg     <= S_IDLE;
                ptr_reg    <= 8'h00;
                sda_oe_reg <= 1'b0;
                got_reg    <= 1'b0;
            end else if (bus_start) begin
                st_reg      <= S_ADDR;
                bit_cnt_reg <= 3'd0;
                got_reg     <= 1'b0;
                sda_oe_reg  <= 1'b0;
            end else if (bus_stop) begin
                st_reg     <= S_IDLE;
                sda_oe_reg <= 1'b0;
            end else if (scl_rise) begin
                case (st_reg)
                    S_ADDR, S_REG, S_WDATA: begin
                        shift_reg   <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 3'd1;
                        if (bit_cnt_reg == 3'd7) begin
                            got_reg <= 1'b1;
                        end
                    end
                    S_RACK: begin
                        if (sda) begin
                            st_reg <= S_IDLE;
                        end else begin
                            st_reg <= S_ACK;
                            nx_reg <= S_RDATA;
                        end
                    end
                    default: begin
                        st_reg <= st_reg;
                    end
                endcase
            end else if (scl_fall) begin
                case (st_reg)
                    S_ADDR: begin
                        if (got_reg) begin
                            got_reg <= 1'b0;
                            if (shift_reg[7:1] == `DEV_ADDR) begin
                                sda_oe_reg <= 1'b1;
                                st_reg     <= S_ACK;
                                nx_reg     <= shift_reg[0] ? S_RDATA : S_REG;
                            end else begin
                                st_reg <= S_IDLE;
                            end
                        end
                    end
                    S_REG: begin
                        if (got_reg) begin
                            got_reg    <= 1'b0;
                            ptr_reg    <= shift_reg;
                            sda_oe_reg <= 1'b1;
                            st_reg     <= S_ACK;
                            nx_reg     <= S_WDATA;
                        end
                    end
                    S_WDATA: begin
                        if (got_reg) begin
                            got_reg    <= 1'b0;
                            ptr_reg    <= ptr_reg + 8'h01;
                            sda_oe_reg <= 1'b1;
                            st_reg     <= S_ACK;
                            nx_reg     <= S_WDATA;
                        end
                    end
                    S_ACK: begin
                        bit_cnt_reg <= 3'd0;
                        st_reg      <= nx_reg;
                        if (nx_reg == S_RDATA) begin
                            shift_reg  <= rd_byte;
                            sda_oe_reg <= ~rd_byte[7];
                            ptr_reg    <= ptr_reg + 8'h01;
                        end else begin
                            sda_oe_reg <= 1'b0;
                        end
                    end
                    S_RDATA: begin
                        if (bit_cnt_reg == 3'd7) begin
                            sda_oe_reg <= 1'b0;
                            st_reg     <= S_RACK;
                        end else begin
                            sda_oe_reg  <= ~shift_reg[6];
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 3'd1;
                        end
                    end
                    default: begin
                        st_reg <= st_reg;
                    end
                endcase
            end
        end
    end

    // fault set and dim set win over a clear in the same cycle
    wire [7:0] fault_set = {3'b000,
                            pin_lvl[`PIN_SHORT],
                            pin_lvl[`PIN_THERMAL],
                            pin_lvl[`PIN_OVP],
                            2'b00};
    wire [7:0] status_clr = wr_status ? (rx_byte & `MASK_FAULT) : 8'h00;
    wire [7:0] status_next = ((status_reg & ~status_clr) | fault_set) & `MASK_FAULT;

    wire [7:0] mode_wr = wr_mode ? (rx_byte & `MASK_MODE) : mode_reg;
    wire [7:0] mode_next = mode_wr | (dim_timeout_in ? (8'h01 << `BIT_DIM) : 8'h00);

    // registers
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_reg   <= `REG_RESET;
            status_reg <= `REG_RESET;
            irq_en_reg <= `REG_RESET;
        end else if (uvlo) begin
            mode_reg   <= `REG_RESET;
            status_reg <= `REG_RESET;
            irq_en_reg <= `REG_RESET;
        end else begin
            mode_reg   <= mode_next;
            status_reg <= status_next;
            if (wr_irq_en) begin
                irq_en_reg <= rx_byte & `MASK_FAULT;
            end
        end
    end

    // interrupt: pending on enabled flags, optional release window
    wire pending = |(status_next & irq_en_reg);
    wire int_cfg = mode_reg[`BIT_INT_CFG];

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rel_cnt_reg <= REL_ZERO;
            irq_n_reg   <= 1'b1;
        end else if (uvlo) begin
            rel_cnt_reg <= REL_ZERO;
            irq_n_reg   <= 1'b1;
        end else begin
            if (clr_try && int_cfg) begin
                rel_cnt_reg <= REL_LOAD;
            end else if (rel_cnt_reg != REL_ZERO) begin
                rel_cnt_reg <= rel_cnt_reg - REL_ONE;
            end
            if (int_cfg) begin
                irq_n_reg <= ~(pending & ~(clr_try | (rel_cnt_reg > REL_ONE)));
            end else begin
                irq_n_reg <= ~pending;
            end
        end
    end

    // controls to the device
    wire active = mode_reg[`BIT_ACTIVE];
    wire bl_on = mode_reg[`BIT_BACKLIGHT_ENABLE] & active;
    wire any_sink_en = |per_sink_enable_in;
    wire sis_on = mode_reg[`BIT_SYNC_INDEP_SINK_ENABLE] & active;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            active_reg     <= 1'b0;
            bl_on_reg      <= 1'b0;
            dim_act_reg    <= 1'b0;
            gain_allow_reg <= 1'b1;
        end else begin
            active_reg     <= active;
            bl_on_reg      <= bl_on;
            dim_act_reg    <= mode_reg[`BIT_DIM] & bl_on;
            gain_allow_reg <= ~mode_reg[`BIT_GAIN_DIS] | leds_all_off_in;
        end
    end

    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_sink
            always @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    sink_on_reg[gi] <= 1'b0;
                end else if (any_sink_en) begin
                    sink_on_reg[gi] <= indep_sink_sel_in[gi] & per_sink_enable_in[gi]
                                       & active;
                end else begin
                    sink_on_reg[gi] <= indep_sink_sel_in[gi] & sis_on;
                end
            end
        end
    endgenerate

    assign sda_out                  = sda_out_reg;
    assign sda_oe_out               = sda_oe_reg;
    assign active_out               = active_reg;
    assign backlight_on_out         = bl_on_reg;
    assign dim_active_out           = dim_act_reg;
    assign pump_gain_down_allow_out = gain_allow_reg;
    assign indep_sink_on_out        = sink_on_reg;
    assign irq_n_out                = irq_n_reg;
endmodule // led_mode_irq

// [bench/led_mode_irq_chk.sv]
// port-level assertions for the mode, fault and interrupt register block
`timescale 1ns/1ps
module led_mode_irq_chk #(
    parameter RELEASE_CYCLES = 6250
) (
    // clock and reset
    input wire       clk_in,
    input wire       resetn_in,
    // inputs watched
    input wire       scl_in,
    input wire       uvlo_in,
    input wire       leds_all_off_in,
    input wire [6:0] per_sink_enable_in,
    input wire [6:0] indep_sink_sel_in,
    // outputs watched
    input wire       sda_oe_out,
    input wire       active_out,
    input wire       backlight_on_out,
    input wire       dim_active_out,
    input wire       pump_gain_down_allow_out,
    input wire [6:0] indep_sink_on_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_uvlo_held;
        uvlo_in [*8];
    endsequence
    sequence s_sink_override;
        |per_sink_enable_in;
    endsequence

    AST_BL_NEEDS_ACTIVE: assert property (backlight_on_out |-> active_out)
        else $error("backlight on outside active mode");
    AST_DIM_NEEDS_BL: assert property (dim_active_out |-> backlight_on_out)
        else $error("dim active without backlight");
    AST_GAIN_LEDS_OFF: assert property (leds_all_off_in |=> pump_gain_down_allow_out)
        else $error("gain down held while all leds off");
    AST_STANDBY_QUIET: assert property (!active_out |-> indep_sink_on_out == 7'h00)
        else $error("sinks on in standby");
    AST_ONLY_INDEP: assert property (
        (indep_sink_on_out & ~$past(indep_sink_sel_in)) == 7'h00)
        else $error("non independent sink switched");
    AST_SINK_OVERRIDE: assert property (s_sink_override |=>
        indep_sink_on_out == ($past(indep_sink_sel_in) & $past(per_sink_enable_in)
        & {7{active_out}}))
        else $error("sync enable not overridden");
    AST_UVLO_CLEARS: assert property (
        s_uvlo_held |=> !active_out && !backlight_on_out)
        else $error("undervoltage left mode set");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data line changed while clock high");
endmodule // led_mode_irq_chk

// [bench/i2c_host.sv]
// serial bus master model standing for the host processor
`timescale 1ns/1ps
module i2c_host (
    // clock
    input  wire  clk_in,
    // bus, released lines pulled high outside
    input  wire  sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // set both lines after an edge, then hold n cycles
    task automatic ph(input logic s, input logic l, input int n);
        scl_out = s;
        sda_low_out = l;
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // also serves as repeated start
    task automatic start();
        ph(scl_out, 1'b0, 5);
        ph(1'b1, 1'b0, 10);
        ph(1'b1, 1'b1, 10);
        ph(1'b0, 1'b1, 5);
    endtask
    task automatic stop();
        ph(1'b0, 1'b1, 5);
        ph(1'b1, 1'b1, 10);
        ph(1'b1, 1'b0, 10);
    endtask
    // eight bits msb first then ninth bit, levels sampled at end of clock high
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
                        output logic r9);
        logic [8:0] v;
        v = {d, b9};
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, ~v[i], 5);
            ph(1'b1, ~v[i], 10);
            if (i > 0) r[i-1] = sda_in;
            else r9 = sda_in;
            ph(1'b0, ~v[i], 5);
        end
    endtask
endmodule // i2c_host

// [bench/test_led_mode_irq.sv]
// self-checking bench for the mode, fault and interrupt register block
`timescale 1ns/1ps
module test_led_mode_irq;
    localparam int REL = 1500;
    logic       clk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic [2:0] det = 3'h0;
    logic       uvlo = 1'b0;
    logic       dim_to = 1'b0;
    logic       all_off = 1'b0;
    logic [6:0] per_sink = 7'h00;
    logic [6:0] sel = 7'h55;
    wire        scl, sda, sda_low, sda_oe, sda_drv, act, bl_on, dim_on, gd_allow, irq_n;
    wire  [6:0] sink_on;
    int         failures = 0;
    int         checks = 0;
    int         run = 0;
    int         last = 0;
    int         highs = 0;
    logic [7:0] rv;
    logic       a;

    assign sda = ~(sda_low | (sda_oe & ~sda_drv));
    always #4 clk_in = ~clk_in;
    // length of each interrupt release, in cycles
    always @(posedge clk_in) begin
        if (irq_n === 1'b1) begin
            run <= run + 1;
            highs <= highs + 1;
        end else begin
            if (run != 0) last <= run;
            run <= 0;
        end
    end

    i2c_host host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    led_mode_irq #(.RELEASE_CYCLES(REL)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .short_det_in(det[2]),
        .thermal_det_in(det[1]), .ovp_det_in(det[0]), .uvlo_in(uvlo),
        .dim_timeout_in(dim_to), .leds_all_off_in(all_off),
        .per_sink_enable_in(per_sink), .indep_sink_sel_in(sel), .active_out(act),
        .backlight_on_out(bl_on), .dim_active_out(dim_on),
        .pump_gain_down_allow_out(gd_allow), .indep_sink_on_out(sink_on),
        .irq_n_out(irq_n));

    task automatic end_of_test();
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        logic k;
        host.start();
        host.xfer(8'h54, 1'b1, r, k);
        chk("addr ack", 8'h00, k);
        host.xfer(p, 1'b1, r, k);
        host.xfer(d, 1'b1, r, k);
        chk("data ack", 8'h00, k);
        host.stop();
    endtask
    task automatic rchk(input string n, input logic [7:0] p, input logic [7:0] e);
        logic k;
        host.start();
        host.xfer(8'h54, 1'b1, rv, k);
        host.xfer(p, 1'b1, rv, k);
        host.start();
        host.xfer(8'h55, 1'b1, rv, k);
        host.xfer(8'hff, 1'b1, rv, k);
        host.stop();
        chk(n, e, rv);
    endtask
    task automatic wait_irq();
        int i;
        for (i = 0; i < 4000 && irq_n !== 1'b0; i++) cyc(1);
        if (i == 4000) begin
            chk("irq wait", 8'h00, 8'h01);
            end_of_test();
        end
        cyc(2);
    endtask

    initial begin
        int h;
        cyc(5);
        resetn_in = 1'b1;
        cyc(8);
        chk("irq", 8'h01, irq_n);
        chk("allow", 8'h01, gd_allow);
        for (int p = 1; p < 4; p++) rchk("reset", p[7:0], 8'h00);
        host.start();
        host.xfer(8'h56, 1'b1, rv, a);
        host.stop();
        chk("nack", 8'h01, a);
        rchk("unmapped", 8'h07, 8'h00);
        wr(8'h01, 8'hff);
        rchk("mode", 8'h01, 8'h7d);
        chk("active", 8'h01, act);
        chk("dim", 8'h01, dim_on);
        chk("allow", 8'h00, gd_allow);
        chk("sinks", 8'h55, sink_on);
        all_off = 1'b1;
        per_sink = 7'h03;
        cyc(3);
        chk("allow", 8'h01, gd_allow);
        chk("sinks", 8'h01, sink_on);
        per_sink = 7'h00;
        wr(8'h01, 8'h20);
        chk("backlight", 8'h00, bl_on);
        chk("sinks", 8'h00, sink_on);
        wr(8'h01, 8'h11);
        chk("backlight", 8'h00, {act, bl_on, dim_on});
        wr(8'h01, 8'h21);
        dim_to = 1'b1;
        cyc(1);
        dim_to = 1'b0;
        cyc(2);
        chk("dim", 8'h01, dim_on);
        rchk("mode", 8'h01, 8'h31);
        wr(8'h03, 8'hff);
        rchk("enable", 8'h03, 8'h1c);
        wr(8'h03, 8'h00);
        for (int i = 0; i < 3; i++) begin
            det[i] = 1'b1;
            cyc(10);
            det[i] = 1'b0;
            cyc(10);
            rchk("flag", 8'h02, 8'h04 << i);
            chk("irq", 8'h01, irq_n);
            wr(8'h03, 8'h04 << i);
            chk("irq", 8'h00, irq_n);
            wr(8'h02, 8'h00);
            rchk("flag", 8'h02, 8'h04 << i);
            wr(8'h02, 8'h04 << i);
            rchk("flag", 8'h02, 8'h00);
            chk("irq", 8'h01, irq_n);
        end
        wr(8'h03, 8'h08);
        det[1] = 1'b1;
        cyc(10);
        chk("irq", 8'h00, irq_n);
        h = highs;
        wr(8'h02, 8'h08);
        chk("held", 8'h00, highs != h);
        det[1] = 1'b0;
        wr(8'h01, 8'h40);
        wr(8'h02, 8'h04);
        wait_irq();
        chk("release", 8'h01, last == REL);
        rchk("flag", 8'h02, 8'h08);
        wr(8'h02, 8'h04);
        wr(8'h02, 8'h04);
        wait_irq();
        chk("restart", 8'h01, last > REL);
        wr(8'h02, 8'h08);
        cyc(REL + 10);
        chk("irq", 8'h01, irq_n);
        wr(8'h01, 8'h60);
        uvlo = 1'b1;
        cyc(12);
        uvlo = 1'b0;
        cyc(8);
        chk("active", 8'h00, act);
        rchk("mode", 8'h01, 8'h00);
        end_of_test();
    end
endmodule // test_led_mode_irq

bind led_mode_irq led_mode_irq_chk #(.RELEASE_CYCLES(RELEASE_CYCLES)) chk (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .uvlo_in(uvlo_in),
    .leds_all_off_in(leds_all_off_in), .per_sink_enable_in(per_sink_enable_in),
    .indep_sink_sel_in(indep_sink_sel_in), .sda_oe_out(sda_oe_out),
    .active_out(active_out), .backlight_on_out(backlight_on_out),
    .dim_active_out(dim_active_out), .pump_gain_down_allow_out(pump_gain_down_allow_out),
    .indep_sink_on_out(indep_sink_on_out));
